// >>> mmd_decoder.sv
// Notes on behaviour
// - Program store contiguous from address zero
// - Top 512 bytes reserved for factory data
// - Program memory is read only, byte reads
// - Part identity byte readable at 0x3FF9
// - Serial number bytes 0x3FFC-0x3FFF read normally
// - 256 internal bytes, lower half both modes
// - Above 0x7F: direct hits registers, indirect RAM
// - Four banks of eight, selected by status bits
// - Bit addresses below 0x80 map onto bytes 0x20-0x2F
// - Bit or byte access chosen by opcode
// - Push writes at pointer plus one, increments
// - Reset sets stack pointer to 0x07
// - 1024 external bytes by pointer or register
// - Eight-bit external moves take page register high
// - Window off: external RAM repeats every 0x0400
// - Page register three bits, rest read zero
// - Window on: 0x0400-0x04FF reach FIFO RAM
// - FIFO accesses take more cycles
// - Window enable is config bit 6, reset clear
`timescale 1ns/10ps
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter int unsigned PROG_BYTES = PROG_BYTES_LARGE,
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT // Arbitrary value
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire mmd_req_s req_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  output mmd_rsp_s rsp_o,
  output logic rsp_valid_o,
  input wire logic [7:0] program_status_word_i,
  output mmd_mem_s prog_o,
  input wire logic [7:0] prog_rdata_i,
  output mmd_mem_s iram_o,
  input wire logic [7:0] iram_rdata_i,
  output mmd_mem_s sfr_o,
  input wire logic [7:0] sfr_rdata_i,
  output mmd_mem_s xram_o,
  input wire logic [7:0] xram_rdata_i,
  output mmd_fifo_s fifo_o,
  input wire logic fifo_ack_i,
  input wire logic [7:0] fifo_rdata_i,
  output logic [7:0] stack_pointer_o,
  output logic [PAGE_W-1:0] xram_page_field_o,
  output logic fifo_window_enable_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_FIFO} mmd_state_e;

  mmd_state_e state, next_state;
  mmd_tgt_e tgt, next_tgt;
  mmd_mem_s cmd, next_cmd;
  logic bit_op, next_bit_op;
  logic [2:0] bit_pos, next_bit_pos;
  logic factory, next_factory;
  logic refused, next_refused;
  logic to_fifo, next_to_fifo;
  logic [7:0] stack_pointer, next_stack_pointer;
  logic [PAGE_W-1:0] xram_page_field, next_xram_page_field;
  logic fifo_window_enable, next_fifo_window_enable;
  mmd_rsp_s rsp, next_rsp;
  logic rsp_valid, next_rsp_valid;
  logic fifo_start;
  logic fifo_done;
  logic [7:0] fifo_rdata;
  logic [1:0] bank;
  logic [7:0] local_rdata;
  logic [7:0] pick;

  // Bank select straight from the core's status word
  assign bank = {program_status_word_i[BANK_HIGH_POS], program_status_word_i[BANK_LOW_POS]};

  // ==========================================================
  // Locally held special registers
  // Bits the block does not implement read back fixed, so software
  // read-modify-write sequences never disturb them.
  always_comb begin
    case (cmd.addr[7:0])
      STACK_ADDR: local_rdata = stack_pointer;
      MEM_CFG_ADDR: local_rdata = MEM_CFG_FIXED | (8'(fifo_window_enable) << WINDOW_EN_POS);
      PAGE_REG_ADDR: local_rdata = {5'h00, xram_page_field};
      default: local_rdata = 8'h00;
    endcase
  end

  // Data source for the answer, chosen by the target kept from decode
  always_comb begin
    case (tgt)
      TG_CODE: pick = prog_rdata_i;
      TG_ID: pick = PART_ID;
      TG_BLANK: pick = BLANK_BYTE;
      TG_IRAM: pick = iram_rdata_i;
      TG_SFR: pick = sfr_rdata_i;
      TG_LOCAL: pick = local_rdata;
      TG_XRAM: pick = xram_rdata_i;
      default: pick = 8'h00;
    endcase
  end

  // ==========================================================
  // Decode and sequencing
  always_comb begin
    logic [15:0] xaddr;
    logic [7:0] a8;
    xaddr = 16'h0000;
    a8 = 8'h00;
    next_state = state;
    next_tgt = tgt;
    next_cmd = cmd;
    next_bit_op = bit_op;
    next_bit_pos = bit_pos;
    next_factory = factory;
    next_refused = refused;
    next_to_fifo = to_fifo;
    next_stack_pointer = stack_pointer;
    next_xram_page_field = xram_page_field;
    next_fifo_window_enable = fifo_window_enable;
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_state = ST_ISSUE;
          next_tgt = TG_NONE;
          next_cmd = '{en: 1'b1, we: req_i.we, addr: 16'h0000, wdata: req_i.wdata, wmask: 8'hff};
          next_bit_op = 1'b0;
          next_bit_pos = 3'h0;
          next_factory = 1'b0;
          next_refused = 1'b0;
          next_to_fifo = 1'b0;
          a8 = req_i.addr[7:0];
          case (req_i.op)
            OP_CODE: begin
              // No write path exists into program space
              if (req_i.we) begin
                next_refused = 1'b1;
              end else if (req_i.addr == PART_ID_ADDR) begin
                next_tgt = TG_ID;
                next_factory = 1'b1;
              end else if (req_i.addr >= FACTORY_BASE && req_i.addr <= FACTORY_LAST) begin
                next_tgt = TG_CODE;
                next_factory = 1'b1;
                next_cmd.addr = req_i.addr;
              end else if (32'(req_i.addr) < PROG_BYTES) begin
                next_tgt = TG_CODE;
                next_cmd.addr = req_i.addr;
              end else begin
                next_tgt = TG_BLANK;
              end
            end
            OP_DIRECT: begin
              next_cmd.addr = {8'h00, a8};
              if (a8 <= DIRECT_RAM_TOP) begin
                next_tgt = TG_IRAM;
              end else if (a8 == STACK_ADDR || a8 == MEM_CFG_ADDR || a8 == PAGE_REG_ADDR) begin
                next_tgt = TG_LOCAL;
              end else begin
                next_tgt = TG_SFR;
              end
            end
            OP_INDIRECT: begin
              next_tgt = TG_IRAM;
              next_cmd.addr = {8'h00, a8};
            end
            OP_REG: begin
              next_tgt = TG_IRAM;
              next_cmd.addr = {11'h000, bank, req_i.addr[2:0]};
            end
            OP_BIT: begin
              // Writes carry a one-bit mask so the array updates in place
              next_bit_op = 1'b1;
              next_bit_pos = a8[2:0];
              next_cmd.wmask = 8'h01 << a8[2:0];
              next_cmd.wdata = {8{req_i.wdata[0]}};
              if (!a8[7]) begin
                next_tgt = TG_IRAM;
                next_cmd.addr = {8'h00, BIT_BYTE_BASE + {4'h0, a8[6:3]}};
              end else begin
                next_tgt = TG_SFR;
                next_cmd.addr = {8'h00, a8[7:3], 3'h0};
              end
            end
            OP_PUSH: begin
              next_tgt = TG_IRAM;
              next_cmd.we = 1'b1;
              next_cmd.addr = {8'h00, stack_pointer + 8'h01};
              next_stack_pointer = stack_pointer + 8'h01;
            end
            OP_POP: begin
              next_tgt = TG_IRAM;
              next_cmd.we = 1'b0;
              next_cmd.addr = {8'h00, stack_pointer};
              next_stack_pointer = stack_pointer - 8'h01;
            end
            OP_XDATA16, OP_XDATA8: begin
              if (req_i.op == OP_XDATA8) begin
                xaddr = {5'h00, xram_page_field, a8};
              end else begin
                xaddr = req_i.addr;
              end
              if (fifo_window_enable && xaddr >= FIFO_FIRST && xaddr <= FIFO_LAST) begin
                next_to_fifo = 1'b1;
                next_cmd.addr = {8'h00, xaddr[7:0]};
              end else begin
                next_tgt = TG_XRAM;
                next_cmd.addr = {6'h00, xaddr[XRAM_AW-1:0]};
              end
            end
            default: begin
              next_refused = 1'b1;
            end
          endcase
        end
      end
      ST_ISSUE: begin
        // Local register writes land here; bits above the page field drop
        if (tgt == TG_LOCAL && cmd.we) begin
          case (cmd.addr[7:0])
            STACK_ADDR: next_stack_pointer = cmd.wdata;
            MEM_CFG_ADDR: next_fifo_window_enable = cmd.wdata[WINDOW_EN_POS];
            PAGE_REG_ADDR: next_xram_page_field = cmd.wdata[PAGE_W-1:0];
            default: next_stack_pointer = stack_pointer;
          endcase
        end
        next_state = to_fifo ? ST_FIFO : ST_CAPTURE;
      end
      ST_CAPTURE: begin
        next_rsp.rdata = bit_op ? {7'h00, pick[bit_pos]} : pick;
        next_rsp.factory = factory;
        next_rsp.refused = refused;
        next_rsp_valid = 1'b1;
        next_state = ST_IDLE;
      end
      ST_FIFO: begin
        // Core stays stalled until the crossed handshake closes
        if (fifo_done) begin
          next_rsp.rdata = fifo_rdata;
          next_rsp.factory = 1'b0;
          next_rsp.refused = 1'b0;
          next_rsp_valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      tgt <= TG_NONE;
      cmd <= '0;
      bit_op <= 1'b0;
      bit_pos <= 3'h0;
      factory <= 1'b0;
      refused <= 1'b0;
      to_fifo <= 1'b0;
      stack_pointer <= STACK_RESET;
      xram_page_field <= PAGE_RESET;
      fifo_window_enable <= 1'b0;
      rsp <= '0;
      rsp_valid <= 1'b0;
    end else begin
      state <= next_state;
      tgt <= next_tgt;
      cmd <= next_cmd;
      bit_op <= next_bit_op;
      bit_pos <= next_bit_pos;
      factory <= next_factory;
      refused <= next_refused;
      to_fifo <= next_to_fifo;
      stack_pointer <= next_stack_pointer;
      xram_page_field <= next_xram_page_field;
      fifo_window_enable <= next_fifo_window_enable;
      rsp <= next_rsp;
      rsp_valid <= next_rsp_valid;
    end
  end

  // ==========================================================
  // Array strobes
  // Strobes last exactly the issue cycle; arrays answer on the next edge.
  // Program space never sees a write strobe.
  always_comb begin
    prog_o = '0;
    iram_o = '0;
    sfr_o = '0;
    xram_o = '0;
    if (state == ST_ISSUE) begin
      case (tgt)
        TG_CODE: begin
          prog_o.en = 1'b1;
          prog_o.addr = cmd.addr;
        end
        TG_IRAM: iram_o = cmd;
        TG_SFR: sfr_o = cmd;
        TG_XRAM: xram_o = cmd;
        default: prog_o = '0;
      endcase
    end
  end

  assign fifo_start = (state == ST_ISSUE) && to_fifo;

  // FIFO RAM lives on the USB clock; a running clock is assumed there
  mmd_fifo_bridge u_fifo_bridge (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(fifo_start),
    .we_i(cmd.we),
    .addr_i(cmd.addr[7:0]),
    .wdata_i(cmd.wdata),
    .fifo_o(fifo_o),
    .fifo_ack_i(fifo_ack_i),
    .fifo_rdata_i(fifo_rdata_i),
    .done_o(fifo_done),
    .rdata_o(fifo_rdata)
  );

  assign req_ready_o = (state == ST_IDLE);
  assign rsp_o = rsp;
  assign rsp_valid_o = rsp_valid;
  assign stack_pointer_o = stack_pointer;
  assign xram_page_field_o = xram_page_field;
  assign fifo_window_enable_o = fifo_window_enable;

endmodule

// >>> mmd_pkg.sv
package mmd_pkg;

  // ==========================================================
  // Program space map
  localparam int unsigned PROG_BYTES_LARGE = 16384;
  localparam int unsigned PROG_BYTES_SMALL = 8192;
  localparam logic [15:0] FACTORY_BASE = 16'h3e00;
  localparam logic [15:0] FACTORY_LAST = 16'h3fff;
  localparam logic [15:0] PART_ID_ADDR = 16'h3ff9;
  localparam logic [15:0] SERIAL_FIRST = 16'h3ffc;
  localparam logic [15:0] SERIAL_LAST = 16'h3fff;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] PART_ID_DEFAULT = 8'h5a; // Arbitrary value

  // ==========================================================
  // Internal data space map
  localparam logic [7:0] DIRECT_RAM_TOP = 8'h7f;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam int unsigned BANK_LOW_POS = 3;
  localparam int unsigned BANK_HIGH_POS = 4;
  localparam logic [7:0] STACK_ADDR = 8'h81;
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] MEM_CFG_ADDR = 8'h85;
  localparam int unsigned WINDOW_EN_POS = 6;
  localparam logic [7:0] MEM_CFG_FIXED = 8'h03;
  localparam logic [7:0] PAGE_REG_ADDR = 8'haa;
  localparam int unsigned PAGE_W = 3;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;

  // ==========================================================
  // External data space map
  localparam int unsigned XRAM_AW = 10;
  localparam logic [15:0] FIFO_FIRST = 16'h0400;
  localparam logic [15:0] FIFO_LAST = 16'h04ff;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    OP_CODE, OP_DIRECT, OP_INDIRECT, OP_REG, OP_BIT,
    OP_PUSH, OP_POP, OP_XDATA16, OP_XDATA8
  } mmd_op_e;

  typedef enum logic [2:0] {
    TG_NONE, TG_CODE, TG_ID, TG_BLANK, TG_IRAM, TG_SFR, TG_LOCAL, TG_XRAM
  } mmd_tgt_e;

  typedef struct packed {
    mmd_op_e op;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmd_req_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic factory;
    logic refused;
  } mmd_rsp_s;

  typedef struct packed {
    logic en;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } mmd_mem_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmd_fifo_s;

endpackage

// >>> mmd_fifo_bridge.sv
`timescale 1ns/10ps
module mmd_fifo_bridge
  import mmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output mmd_fifo_s fifo_o,
  input wire logic fifo_ack_i,
  input wire logic [7:0] fifo_rdata_i,
  output logic done_o,
  output logic [7:0] rdata_o
);

  typedef enum logic [1:0] {BR_IDLE, BR_WAIT_HIGH, BR_WAIT_LOW} mmd_br_e;

  mmd_br_e state, next_state;
  mmd_fifo_s cmd, next_cmd;
  logic [7:0] rdata, next_rdata;
  logic done, next_done;
  logic [2:0] ack_sync;
  logic ack_high, ack_low;

  // ==========================================================
  // Acknowledge crossing
  // The acknowledge toggles on the USB clock; three stages, and a change
  // is only believed once the last two stages agree.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_sync <= 3'h0;
    end else begin
      ack_sync <= {ack_sync[1:0], fifo_ack_i};
    end
  end

  assign ack_high = ack_sync[1] & ack_sync[2];
  assign ack_low = ~ack_sync[1] & ~ack_sync[2];

  // ==========================================================
  // Four-phase handshake
  // Address and data stay frozen while req is high, so the far side may
  // sample them at any USB edge. Read data is taken only after the
  // acknowledge has crossed, when the far side holds it still.
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      BR_IDLE: begin
        if (start_i) begin
          next_cmd = '{req: 1'b1, we: we_i, addr: addr_i, wdata: wdata_i};
          next_state = BR_WAIT_HIGH;
        end
      end
      BR_WAIT_HIGH: begin
        if (ack_high) begin
          next_rdata = fifo_rdata_i;
          next_cmd.req = 1'b0;
          next_state = BR_WAIT_LOW;
        end
      end
      BR_WAIT_LOW: begin
        if (ack_low) begin
          next_done = 1'b1;
          next_state = BR_IDLE;
        end
      end
      default: begin
        next_state = BR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= BR_IDLE;
      cmd <= '0;
      rdata <= 8'h00;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      rdata <= next_rdata;
      done <= next_done;
    end
  end

  assign fifo_o = cmd;
  assign done_o = done;
  assign rdata_o = rdata;

endmodule

// >>> mmd_decoder_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker for the memory map decoder
module mmd_decoder_sva
  import mmd_pkg::*;
#(
  parameter int unsigned PROG_BYTES = PROG_BYTES_LARGE,
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire mmd_req_s req_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire mmd_rsp_s rsp_o,
  input wire logic rsp_valid_o,
  input wire logic [7:0] program_status_word_i,
  input wire mmd_mem_s prog_o,
  input wire mmd_mem_s iram_o,
  input wire mmd_mem_s sfr_o,
  input wire mmd_mem_s xram_o,
  input wire mmd_fifo_s fifo_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic [PAGE_W-1:0] xram_page_field_o,
  input wire logic fifo_window_enable_o
);
  // A request counts only on the edge where both sides agree
  wire logic take = req_valid_i && req_ready_o;
  wire logic code_rd = take && req_i.op == OP_CODE && !req_i.we;
  wire logic in_fifo = req_i.addr >= FIFO_FIRST && req_i.addr <= FIFO_LAST && fifo_window_enable_o;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  plain_lat_a: assert property (take && req_i.op inside {OP_CODE, OP_DIRECT, OP_INDIRECT, OP_REG, OP_BIT, OP_PUSH,
    OP_POP} |=> !rsp_valid_o [*2] ##1 rsp_valid_o) else $error("plain answer not three cycles after take");
  code_ro_a: assert property (prog_o.en |-> !prog_o.we) else $error("program strobe with write");
  code_wr_a: assert property (take && req_i.op == OP_CODE && req_i.we |=> !prog_o.en ##2 rsp_o.refused)
    else $error("program write not refused");
  part_id_a: assert property (code_rd && req_i.addr == PART_ID_ADDR |=> ##2 rsp_o.rdata == PART_ID && rsp_o.factory)
    else $error("identity byte wrong");
  factory_a: assert property (code_rd && req_i.addr >= FACTORY_BASE && req_i.addr <= FACTORY_LAST
    && req_i.addr != PART_ID_ADDR |=> prog_o.en && prog_o.addr == $past(req_i.addr) ##2 rsp_o.factory)
    else $error("factory read wrong");
  user_code_a: assert property (code_rd && req_i.addr < FACTORY_BASE && req_i.addr < PROG_BYTES |=> prog_o.en
    ##2 !rsp_o.factory) else $error("user program read wrong");
  push_a: assert property (take && req_i.op == OP_PUSH |=> iram_o.en && iram_o.we && stack_pointer_o ==
    iram_o.addr[7:0] && iram_o.addr[7:0] == $past(stack_pointer_o) + 8'h01) else $error("push address wrong");
  reset_val_a: assert property ($fell(rst_i) |-> stack_pointer_o == STACK_RESET && xram_page_field_o == 3'h0
    && !fifo_window_enable_o) else $error("state not at reset value");
  indirect_a: assert property (take && req_i.op == OP_INDIRECT |=> iram_o.en && !sfr_o.en
    && iram_o.addr[7:0] == $past(req_i.addr[7:0])) else $error("indirect access misrouted");
  direct_sfr_a: assert property (take && req_i.op == OP_DIRECT && req_i.addr[7:0] == 8'h90 |=> sfr_o.en
    && !iram_o.en) else $error("direct upper access missed registers");
  bank_a: assert property (take && req_i.op == OP_REG |=> iram_o.en && iram_o.addr[7:0] ==
    {3'h0, $past(program_status_word_i[4:3]), $past(req_i.addr[2:0])}) else $error("bank register misplaced");
  bit_a: assert property (take && req_i.op == OP_BIT && !req_i.addr[7] |=> iram_o.en && iram_o.addr[7:0] ==
    BIT_BYTE_BASE + {4'h0, $past(req_i.addr[6:3])} && (!iram_o.we || iram_o.wmask == 8'h01 << $past(req_i.addr[2:0])))
    else $error("bit access misplaced");
  alias_a: assert property (take && req_i.op == OP_XDATA16 && !in_fifo |=> xram_o.en
    && xram_o.addr == {6'h00, $past(req_i.addr[9:0])}) else $error("external alias wrong");
  page_a: assert property (take && req_i.op == OP_XDATA8 && !fifo_window_enable_o |=> xram_o.en
    && xram_o.addr[9:0] == {$past(xram_page_field_o[1:0]), $past(req_i.addr[7:0])}) else $error("page not used");
  fifo_a: assert property (take && req_i.op == OP_XDATA16 && in_fifo |=> !xram_o.en && !rsp_valid_o ##1
    fifo_o.req && fifo_o.addr == $past(req_i.addr[7:0], 2) && !rsp_valid_o ##1 !rsp_valid_o [*2])
    else $error("window access wrong");
  fifo_hold_a: assert property (fifo_o.req && $past(fifo_o.req) |-> $stable(fifo_o.addr) && $stable(fifo_o.we))
    else $error("handshake fields moved");
endmodule

bind mmd_decoder mmd_decoder_sva #(.PROG_BYTES(PROG_BYTES), .PART_ID(PART_ID)) i_sva (.mclk_i(mclk_i),
  .rst_i(rst_i), .req_i(req_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rsp_o(rsp_o),
  .rsp_valid_o(rsp_valid_o), .program_status_word_i(program_status_word_i), .prog_o(prog_o), .iram_o(iram_o),
  .sfr_o(sfr_o), .xram_o(xram_o), .fifo_o(fifo_o), .stack_pointer_o(stack_pointer_o),
  .xram_page_field_o(xram_page_field_o), .fifo_window_enable_o(fifo_window_enable_o));

// >>> mmd_mem_model.sv
`timescale 1ns/10ps
// ==========================================================
// Arrays and FIFO RAM on the far side of the decoder
module mmd_mem_model
  import mmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic slow_i,
  input wire mmd_mem_s prog_i,
  input wire mmd_mem_s iram_i,
  input wire mmd_mem_s sfr_i,
  input wire mmd_mem_s xram_i,
  input wire mmd_fifo_s fifo_i,
  output logic [7:0] prog_rdata_o,
  output logic [7:0] iram_rdata_o,
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] xram_rdata_o,
  output logic fifo_ack_o,
  output logic [7:0] fifo_rdata_o
);
  logic [7:0] iram [256];
  logic [7:0] sfr [256];
  logic [7:0] xram [1024];
  logic [7:0] fram [256];
  logic [3:0] wait_cnt;

  initial begin
    {prog_rdata_o, iram_rdata_o, sfr_rdata_o, xram_rdata_o, fifo_rdata_o} = '0;
    fifo_ack_o = 1'b0;
    wait_cnt = 4'h0;
  end

  // Sync reads; idle buses flip so a stale byte never passes for data
  always @(posedge mclk_i) begin
    prog_rdata_o <= prog_i.en ? (prog_i.addr[7:0] ^ prog_i.addr[15:8]) : ~prog_rdata_o;
    iram_rdata_o <= iram_i.en ? iram[iram_i.addr[7:0]] : ~iram_rdata_o;
    sfr_rdata_o <= sfr_i.en ? sfr[sfr_i.addr[7:0]] : ~sfr_rdata_o;
    xram_rdata_o <= xram_i.en ? xram[xram_i.addr[9:0]] : ~xram_rdata_o;
    if (iram_i.en && iram_i.we) iram[iram_i.addr[7:0]] <= (iram[iram_i.addr[7:0]] & ~iram_i.wmask) |
      (iram_i.wdata & iram_i.wmask);
    if (sfr_i.en && sfr_i.we) sfr[sfr_i.addr[7:0]] <= sfr_i.wdata;
    if (xram_i.en && xram_i.we) xram[xram_i.addr[9:0]] <= xram_i.wdata;
  end

  // USB side runs fast and always on; slow mode only stretches the ack
  always @(posedge mclk_i) begin
    if (fifo_i.req != fifo_ack_o) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= (slow_i ? 4'h9 : 4'h1)) begin
        wait_cnt <= 4'h0;
        fifo_ack_o <= fifo_i.req;
        if (fifo_i.req && fifo_i.we) fram[fifo_i.addr] <= fifo_i.wdata;
        fifo_rdata_o <= fifo_i.req ? fram[fifo_i.addr] : ~fifo_rdata_o;
      end
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench acting as the core
module tb;
  import mmd_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  mmd_req_s req_i = '0;
  logic req_valid_i = 1'b0;
  logic [7:0] program_status_word = 8'h00;
  logic slow = 1'b0;
  logic req_ready_o, rsp_valid_o, fifo_ack, win;
  mmd_rsp_s rsp_o, r;
  mmd_mem_s prog_o, iram_o, sfr_o, xram_o;
  mmd_fifo_s fifo_o;
  logic [7:0] prog_rd, iram_rd, sfr_rd, xram_rd, fifo_rd, sp;
  logic [PAGE_W-1:0] page;
  logic [15:0] pa [6] = '{16'h0000, 16'h2000, 16'h3dff, 16'h3e00, 16'h3ffc, 16'h3fff};
  int fail_count = 0;
  int samples_checked = 0;
  int lat;

  always #2.5 mclk_i = ~mclk_i;

  mmd_decoder i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o), .program_status_word_i(program_status_word),
    .prog_o(prog_o), .prog_rdata_i(prog_rd), .iram_o(iram_o), .iram_rdata_i(iram_rd), .sfr_o(sfr_o),
    .sfr_rdata_i(sfr_rd), .xram_o(xram_o), .xram_rdata_i(xram_rd), .fifo_o(fifo_o), .fifo_ack_i(fifo_ack),
    .fifo_rdata_i(fifo_rd), .stack_pointer_o(sp), .xram_page_field_o(page), .fifo_window_enable_o(win));

  mmd_mem_model i_mem (.mclk_i(mclk_i), .slow_i(slow), .prog_i(prog_o), .iram_i(iram_o), .sfr_i(sfr_o),
    .xram_i(xram_o), .fifo_i(fifo_o), .prog_rdata_o(prog_rd), .iram_rdata_o(iram_rd), .sfr_rdata_o(sfr_rd),
    .xram_rdata_o(xram_rd), .fifo_ack_o(fifo_ack), .fifo_rdata_o(fifo_rd));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One request, held for its take edge, then a bounded wait for the answer
  task automatic acc(input mmd_op_e op, input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_i <= '{op: op, we: we, addr: a, wdata: d};
    req_valid_i <= 1'b1;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    lat = 0;
    do begin
      @(negedge mclk_i);
      lat++;
    end while (rsp_valid_o !== 1'b1 && lat < 200);
    if (lat >= 200) begin
      fail_count++;
      test_done();
    end
    r = rsp_o;
  endtask

  task automatic rd(input mmd_op_e op, input logic [15:0] a, input logic [7:0] exp);
    acc(op, 1'b0, a, 8'h00);
    chk(r.rdata, exp);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(OP_DIRECT, 16'h0081, 8'h07);
    chk(16'(lat), 16'h3);
    rd(OP_DIRECT, 16'h00aa, 8'h00);
    rd(OP_DIRECT, 16'h0085, MEM_CFG_FIXED);
    acc(OP_PUSH, 1'b1, 16'h0000, 8'ha5);
    chk(sp, 8'h08);
    rd(OP_DIRECT, 16'h0008, 8'ha5);
    rd(OP_POP, 16'h0000, 8'ha5);
    chk(sp, 8'h07);
    acc(OP_CODE, 1'b1, 16'h0010, 8'h00);
    chk({r.refused, r.rdata}, 16'h0100);
    foreach (pa[i]) begin
      rd(OP_CODE, pa[i], pa[i][7:0] ^ pa[i][15:8]);
      chk(r.factory, pa[i] >= 16'h3e00);
    end
    rd(OP_CODE, 16'h3ff9, PART_ID_DEFAULT);
    chk(r.factory, 1'b1);
    rd(OP_CODE, 16'h4000, BLANK_BYTE);
    acc(OP_DIRECT, 1'b1, 16'h0030, 8'h5c);
    rd(OP_INDIRECT, 16'h0030, 8'h5c);
    acc(OP_INDIRECT, 1'b1, 16'h0090, 8'h66);
    acc(OP_DIRECT, 1'b1, 16'h0090, 8'h99);
    rd(OP_INDIRECT, 16'h0090, 8'h66);
    rd(OP_DIRECT, 16'h0090, 8'h99);
    for (int b = 0; b < 4; b++) begin
      @(posedge mclk_i);
      program_status_word <= 8'(b << 3);
      acc(OP_REG, 1'b1, 16'h0001, 8'(8'h40 + b));
      rd(OP_INDIRECT, 16'(8 * b + 1), 8'(8'h40 + b));
    end
    acc(OP_DIRECT, 1'b1, 16'h0022, 8'h00);
    acc(OP_BIT, 1'b1, 16'h0013, 8'hff);
    rd(OP_DIRECT, 16'h0022, 8'h08);
    rd(OP_BIT, 16'h0013, 8'h01);
    rd(OP_BIT, 16'h0012, 8'h00);
    acc(OP_XDATA16, 1'b1, 16'h0123, 8'h3c);
    rd(OP_XDATA16, 16'hfd23, 8'h3c);
    acc(OP_DIRECT, 1'b1, 16'h00aa, 8'hf9);
    rd(OP_DIRECT, 16'h00aa, 8'h01);
    chk(page, 3'h1);
    rd(OP_XDATA8, 16'h0023, 8'h3c);
    acc(OP_XDATA16, 1'b1, 16'h0010, 8'h11);
    acc(OP_XDATA16, 1'b1, 16'h00f0, 8'h22);
    acc(OP_DIRECT, 1'b1, 16'h0085, 8'hff);
    rd(OP_DIRECT, 16'h0085, 8'h43);
    chk(win, 1'b1);
    // Upper FIFO bytes only, kept clear of packet areas
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk_i);
      slow <= s[0];
      acc(OP_XDATA16, 1'b1, 16'h04f0, 8'(8'h70 + s));
      rd(OP_XDATA16, 16'h04f0, 8'(8'h70 + s));
      chk(16'(lat > 3), 16'h1);
    end
    // Paged moves reach the window too once the page points at it
    acc(OP_DIRECT, 1'b1, 16'h00aa, 8'h04);
    rd(OP_XDATA8, 16'h00f0, 8'h71);
    rd(OP_XDATA16, 16'h0010, 8'h11);
    acc(OP_DIRECT, 1'b1, 16'h0085, 8'h00);
    rd(OP_XDATA16, 16'h0410, 8'h11);
    // Window writes must not have touched the RAM hidden behind it
    rd(OP_XDATA16, 16'h04f0, 8'h22);
    test_done();
  end
endmodule
